// >>> dv/cfg_host.sv
// Host model: issues configuration words as one-cycle write strobes
`timescale 1ns/1ps
module cfg_host (
   input  wire logic   mclk,
   output logic        cfg_we,
   output logic [19:0] cfg_word
);
   import load_scale_pkg::*;
   initial cfg_we = 1'b0;
   initial cfg_word = 20'h00000;
   task automatic put(input logic [19:0] w);
      @(posedge mclk) #1 cfg_we = 1'b1;
      cfg_word = w;
      @(posedge mclk) #1 cfg_we = 1'b0;
      cfg_word = ~w; // Released bus never shows the stale word
   endtask
   // Reserved positions always sent as zero
   task automatic adapt(input logic f, logic [1:0] d, logic [3:0] o, logic [1:0] i, logic [3:0] l);
      put({ADDR_ADAPT, 1'b0, f, d, 1'b0, o, 1'b0, i, 1'b0, l});
   endtask
   // Callers keep sensitivity at -10 or above
   task automatic scale(input logic fl, logic [6:0] s, logic [4:0] c);
      put({ADDR_SCALE, fl, 1'b0, s, 3'b000, c});
   endtask
endmodule

// >>> dv/load_scaling_props.sv
// Checker: port-level properties of the adaptive current scaling block
`timescale 1ns/1ps
module load_scaling_props #(
   parameter int CUR_W = 9
) (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire logic                    cfg_we,
   input wire logic [19:0]             cfg_word,
   input wire logic                    sample_valid,
   input wire logic [9:0]              sample_in,
   input wire logic signed [CUR_W-1:0] cur_a_in,
   input wire logic signed [CUR_W-1:0] cur_b_in,
   input wire logic signed [CUR_W-1:0] cur_a_out,
   input wire logic signed [CUR_W-1:0] cur_b_out,
   input wire logic [4:0]              active_scale,
   input wire logic signed [6:0]       sens_threshold,
   input wire logic                    filter_en,
   input wire logic [9:0]              load_value,
   input wire logic                    load_valid
);
   import load_scale_pkg::*;
   logic [3:0]              low_r;
   logic [1:0]              inc_r;
   logic                    flq_r, q1_r, q2_r, quiet;
   logic [4:0]              cs_r, flo, tgt;
   logic [5:0]              half, up;
   logic signed [CUR_W+6:0] ea, eb;
   always_ff @(posedge mclk) begin
      if (!rst_n) {flq_r, low_r, inc_r} <= 7'h00;
      else if (cfg_we && cfg_word[19:17] == ADDR_ADAPT) {flq_r, low_r, inc_r} <= {cfg_word[15], cfg_word[3:0], cfg_word[6:5]};
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) cs_r <= 5'h00;
      else if (cfg_we && cfg_word[19:17] == ADDR_SCALE) cs_r <= cfg_word[4:0];
   end
   // Settling window: a write reaches the running scale two edges later
   always_ff @(posedge mclk) begin
      q1_r <= rst_n && cfg_we;
      q2_r <= q1_r;
   end
   assign quiet = !cfg_we && !q1_r && !q2_r;
   assign half = (6'(cs_r) + 6'h01) >> (flq_r ? 2 : 1);
   assign flo = (half == 6'h00) ? 5'h00 : 5'(half - 6'h01);
   assign up = 6'(active_scale) + (6'h01 << inc_r);
   assign tgt = (up > 6'(cs_r)) ? cs_r : up[4:0];
   assign ea = (cur_a_in * $signed({2'b00, active_scale} + 7'h01)) >>> 5;
   assign eb = (cur_b_in * $signed({2'b00, active_scale} + 7'h01)) >>> 5;
   // ------
   // Properties
   // ------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_scale_word_taken:
   assert property (cfg_we && cfg_word[19:17] == ADDR_SCALE |=> sens_threshold == $past(cfg_word[14:8]) && filter_en == $past(cfg_word[16])) else $error("scale word fields not taken");
   a_other_word_ignored:
   assert property (cfg_we && cfg_word[19:17] != ADDR_SCALE |=> $stable(sens_threshold) && $stable(filter_en)) else $error("scale fields moved on other word");
   a_sample_passed:
   assert property (sample_valid && !filter_en |=> load_valid && load_value == $past(sample_in)) else $error("unfiltered sample not passed");
   a_coil_scaled:
   assert property (1'b1 |=> cur_a_out == $past(ea[CUR_W-1:0]) && cur_b_out == $past(eb[CUR_W-1:0])) else $error("coil current scaling wrong");
   a_disabled_tracks:
   assert property (low_r == 4'h0 && quiet |-> active_scale == cs_r) else $error("disabled scale differs from setting");
   a_scale_ceiling:
   assert property (quiet |-> active_scale <= cs_r) else $error("running scale above setting");
   a_step_down:
   assert property (low_r != 4'h0 && quiet |=> active_scale >= $past(active_scale) || (active_scale == $past(active_scale) - 5'h01 && active_scale >= flo)) else $error("bad decrement");
   a_step_up:
   assert property (load_valid && low_r != 4'h0 && load_value < {low_r, 5'h00} && quiet |=> active_scale == $past(tgt)) else $error("bad increment");
endmodule
bind load_scaling load_scaling_props #(.CUR_W(CUR_W)) props_u (.mclk, .rst_n, .cfg_we, .cfg_word,
   .sample_valid, .sample_in, .cur_a_in, .cur_b_in, .cur_a_out, .cur_b_out, .active_scale,
   .sens_threshold, .filter_en, .load_value, .load_valid);

// >>> dv/load_scaling_test.sv
// Testbench: directed scenarios for the adaptive current scaling block
`timescale 1ns/1ps
module load_scaling_test;
   import load_scale_pkg::*;
   logic              mclk = 1'b0, rst_n = 1'b0, fullstep = 1'b0, sample_valid = 1'b0;
   logic              cfg_we, filter_en, load_valid;
   logic [19:0]       cfg_word;
   logic [9:0]        sample_in = 10'h000, load_value;
   logic signed [8:0] cur_a_in = 9'h100, cur_b_in = 9'h0FF, cur_a_out, cur_b_out;
   logic [4:0]        active_scale;
   logic signed [6:0] sens_threshold;
   int                mismatches = 0, n_tests = 0, cyc = 0, pulses = 0;
   always #5 mclk = ~mclk;
   cfg_host host_u (.mclk, .cfg_we, .cfg_word);
   load_scaling #(.CUR_W(9)) dut_u (.mclk, .rst_n, .cfg_we, .cfg_word, .fullstep, .sample_valid,
      .sample_in, .cur_a_in, .cur_b_in, .cur_a_out, .cur_b_out, .active_scale, .sens_threshold,
      .filter_en, .load_value, .load_valid);
   always @(posedge mclk) begin
      cyc++;
      if (load_valid === 1'b1) pulses++;
      if (cyc == 6000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out();
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [9:0] e, logic [9:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic ca(string n, logic [4:0] e);
      chk(n, 10'(e), 10'(active_scale));
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Each sample is a one-cycle strobe, then the bus is scrambled
   task automatic samp(logic [9:0] v, int n);
      repeat (n) begin
         @(posedge mclk) #1 sample_valid = 1'b1;
         sample_in = v;
         @(posedge mclk) #1 sample_valid = 1'b0;
         sample_in = ~v;
         idle(2);
      end
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_words();
      host_u.scale(1'b0, -7'sd10, 5'h1F);
      host_u.put(20'hFFFFF);
      host_u.adapt(1'b1, 2'h3, 4'hF, 2'h3, 4'h0);
      idle(2);
      chk("sens", 10'h076, 10'(sens_threshold[6:0]));
      chk("filter", 10'h000, 10'(filter_en));
      ca("track", 5'h1F);
      chk("cur_a", 10'h100, 10'(cur_a_out[8:0]));
      host_u.scale(1'b0, -7'sd10, 5'h00);
      idle(3);
      chk("cur_a", 10'h1F8, 10'(cur_a_out[8:0]));
      chk("cur_b", 10'h007, 10'(cur_b_out[8:0]));
   endtask
   task automatic t_adapt();
      host_u.scale(1'b0, -7'sd10, 5'h0F);
      host_u.adapt(1'b0, 2'h2, 4'h0, 2'h1, 4'h1);
      samp(10'd63, 4);
      ca("hold", 5'h0F);
      samp(10'd64, 20);
      ca("floor", 5'h07);
      samp(10'd31, 3);
      ca("rise", 5'h0D);
      samp(10'd0, 2);
      ca("clamp", 5'h0F);
      host_u.adapt(1'b1, 2'h3, 4'h0, 2'h0, 4'h1);
      samp(10'h3FF, 16);
      ca("quarter", 5'h03);
      host_u.adapt(1'b0, 2'h0, 4'h0, 2'h0, 4'h0);
      idle(3);
      ca("off", 5'h0F);
   endtask
   task automatic t_codes();
      int n[4] = '{32, 8, 2, 1};
      for (int i = 0; i < 4; i++) begin
         host_u.adapt(1'b0, 2'(i), 4'h0, 2'h3, 4'h1);
         samp(10'd0, 1);
         samp(10'd64, n[i]);
         ca("dec", 5'h0E);
      end
      for (int i = 0; i < 4; i++) begin
         host_u.adapt(1'b0, 2'h3, 4'h0, 2'(i), 4'h1);
         samp(10'd64, 10);
         samp(10'd31, 1);
         ca("inc", 5'(7 + (1 << i)));
      end
      host_u.adapt(1'b0, 2'h3, 4'h1, 2'h0, 4'h1);
      samp(10'd95, 2);
      ca("upper_hold", 5'h0F);
      samp(10'd96, 1);
      ca("upper_dec", 5'h0E);
   endtask
   task automatic t_filter();
      host_u.scale(1'b1, -7'sd10, 5'h0F);
      idle(2);
      chk("filter", 10'h001, 10'(filter_en));
      pulses = 0;
      samp(10'd100, 1);
      repeat (4) begin
         chk("early", 10'h000, 10'(pulses));
         @(posedge mclk) #1 fullstep = 1'b1;
         @(posedge mclk) #1 fullstep = 1'b0;
         idle(4);
      end
      chk("late", 10'h001, 10'(pulses));
      chk("value", 10'd100, load_value);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      #1 rst_n = 1'b1;
      t_words();
      t_adapt();
      t_codes();
      t_filter();
      close_out();
   end
endmodule

// >>> hdl/load_filter.sv
// Load sample gate: passes every sample, or one per four full steps when filtered
`timescale 1ns/1ps
module load_filter (
   input  wire logic                                 mclk,
   input  wire logic                                 rst_n,
   input  wire logic                                 filter_en,
   input  wire logic                                 fullstep,
   input  wire logic                                 sample_valid,
   input  wire logic [load_scale_pkg::SAMPLE_W-1:0]  sample_in,
   output logic                                      out_valid,
   output logic [load_scale_pkg::SAMPLE_W-1:0]       out_value
);
   import load_scale_pkg::*;

   logic [1:0]          step_cnt_r;
   logic                window_done_r;
   logic [SAMPLE_W-1:0] hold_r;

   // Counts full steps; filtered value is released once per four
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         step_cnt_r    <= 2'h0;
         window_done_r <= 1'b0;
      end else begin
         window_done_r <= 1'b0;
         if (fullstep) begin
            step_cnt_r <= step_cnt_r + 2'h1;
            if (step_cnt_r == 2'(FULLSTEP_DIV - 1))
               window_done_r <= 1'b1;
         end
      end
   end

   // Latest sample is the measurement reported at the window edge
   always_ff @(posedge mclk) begin
      if (!rst_n)
         hold_r <= '0;
      else if (sample_valid)
         hold_r <= sample_in;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_value <= '0;
      end else if (!filter_en) begin
         out_valid <= sample_valid;
         out_value <= sample_in;
      end else begin
         out_valid <= window_done_r;
         out_value <= hold_r;
      end
   end
endmodule

// >>> hdl/load_scale_pkg.sv
// Package: field layout, address codes and limits of the adaptive current scaling block
package load_scale_pkg;
   localparam int          WORD_W        = 20;
   localparam int          ADDR_HI       = 19;
   localparam int          ADDR_LO       = 17;
   localparam logic [2:0]  ADDR_ADAPT    = 3'h5;
   localparam logic [2:0]  ADDR_SCALE    = 3'h6;
   // Adaptive word fields
   localparam int          LOWER_LO      = 0;
   localparam int          INC_LO        = 5;
   localparam int          UPPER_LO      = 8;
   localparam int          DEC_LO        = 13;
   localparam int          FLOOR_BIT     = 15;
   // Load-measure / scale word fields
   localparam int          CS_LO         = 0;
   localparam int          SENS_LO       = 8;
   localparam int          FILT_BIT      = 16;
   localparam int          THRESH_MULT   = 32;
   localparam int          SAMPLE_W      = 10;
   localparam int          SCALE_W       = 5;
   localparam int          FULLSTEP_DIV  = 4;
   localparam logic [19:0] WORD_RESET    = 20'h00000;

   typedef struct packed {
      logic       floor_quarter;
      logic [1:0] dec_code;
      logic [3:0] upper_off;
      logic [1:0] inc_code;
      logic [3:0] lower;
   } adapt_cfg_s;

   typedef struct packed {
      logic              filter_en;
      logic signed [6:0] sens;
      logic [4:0]        cs;
   } scale_cfg_s;
endpackage

// >>> hdl/load_scaling.sv
// Adaptive coil current scaling: config word decode and current scale control
// Function
// - Top bits 101 select the adaptive current configuration word.
// - Top bits 110 select the load-measurement and current-scale word.
// - Adaptive scale never falls below half, or quarter, of programmed scale.
// - Decrement once per 32, 8, 2 or 1 samples at/above upper threshold.
// - Upper threshold is (lower + offset + 1) times 32.
// - Sample below lower threshold raises scale by 1, 2, 4 or 8.
// - Lower threshold field zero disables adaptive scaling.
// - Compare samples against lower field times 32; below means increase.
// - Filter bit selects every sample or one per four full steps.
// - Sensitivity threshold is seven-bit two's complement, -64 to +63.
// - Coil currents scale by (scale + 1) / 32.
`timescale 1ns/1ps
module load_scaling #(
   parameter int CUR_W = 9
) (
   input  wire logic                                 mclk,
   input  wire logic                                 rst_n,
   input  wire logic                                 cfg_we,
   input  wire logic [load_scale_pkg::WORD_W-1:0]    cfg_word,
   input  wire logic                                 fullstep,
   input  wire logic                                 sample_valid,
   input  wire logic [load_scale_pkg::SAMPLE_W-1:0]  sample_in,
   input  wire logic signed [CUR_W-1:0]              cur_a_in,
   input  wire logic signed [CUR_W-1:0]              cur_b_in,
   output logic signed [CUR_W-1:0]                   cur_a_out,
   output logic signed [CUR_W-1:0]                   cur_b_out,
   output logic [load_scale_pkg::SCALE_W-1:0]        active_scale,
   output logic signed [6:0]                         sens_threshold,
   output logic                                      filter_en,
   output logic [load_scale_pkg::SAMPLE_W-1:0]       load_value,
   output logic                                      load_valid
);
   import load_scale_pkg::*;

   // Product width and the +1 scale bias are only sized for this range
   if (CUR_W < 2 || CUR_W > 16) begin : g_bad_cur_w
      $error("CUR_W out of range");
   end

   // ------------------------------------------------------------
   // Configuration words
   // ------------------------------------------------------------
   adapt_cfg_s adapt_r;
   scale_cfg_s scale_r;
   logic [2:0] addr;
   assign addr = cfg_word[ADDR_HI:ADDR_LO];

   // Reserved positions are simply never captured
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         adapt_r <= '0;
      end else if (cfg_we && addr == ADDR_ADAPT) begin
         adapt_r.floor_quarter <= cfg_word[FLOOR_BIT];
         adapt_r.dec_code      <= cfg_word[DEC_LO +: 2];
         adapt_r.upper_off     <= cfg_word[UPPER_LO +: 4];
         adapt_r.inc_code      <= cfg_word[INC_LO +: 2];
         adapt_r.lower         <= cfg_word[LOWER_LO +: 4];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scale_r <= '0;
      end else if (cfg_we && addr == ADDR_SCALE) begin
         scale_r.filter_en <= cfg_word[FILT_BIT];
         scale_r.sens      <= signed'(cfg_word[SENS_LO +: 7]);
         scale_r.cs        <= cfg_word[CS_LO +: SCALE_W];
      end
   end

   // Sensitivity is only passed on; values below -10 are the host's concern
   assign sens_threshold = scale_r.sens;
   assign filter_en      = scale_r.filter_en;

   // ------------------------------------------------------------
   // Load measurement
   // ------------------------------------------------------------
   load_filter u_filter (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .filter_en    (scale_r.filter_en),
      .fullstep     (fullstep),
      .sample_valid (sample_valid),
      .sample_in    (sample_in),
      .out_valid    (load_valid),
      .out_value    (load_value)
   );

   // ------------------------------------------------------------
   // Thresholds and step sizes
   // ------------------------------------------------------------
   logic [SAMPLE_W:0] lower_thr;
   logic [SAMPLE_W:0] upper_thr;
   logic [5:0]        dec_samples;
   logic [3:0]        inc_step;
   logic [SCALE_W-1:0] floor_val;
   logic              adapt_on;

   assign lower_thr = (SAMPLE_W + 1)'(adapt_r.lower) * (SAMPLE_W + 1)'(THRESH_MULT);
   assign upper_thr = ((SAMPLE_W + 1)'(adapt_r.lower) + (SAMPLE_W + 1)'(adapt_r.upper_off)
                       + (SAMPLE_W + 1)'(1)) * (SAMPLE_W + 1)'(THRESH_MULT);
   assign adapt_on  = (adapt_r.lower != 4'h0);
   assign inc_step  = 4'h1 << adapt_r.inc_code;

   always_comb begin
      unique case (adapt_r.dec_code)
         2'h0: dec_samples = 6'h20;
         2'h1: dec_samples = 6'h08;
         2'h2: dec_samples = 6'h02;
         2'h3: dec_samples = 6'h01;
      endcase
   end

   // Floor in scale-register units: (cs+1)/2 or (cs+1)/4, minus the +1 bias
   logic [SCALE_W:0] cs_plus;
   logic [SCALE_W:0] floor_plus;
   assign cs_plus    = (SCALE_W + 1)'(scale_r.cs) + (SCALE_W + 1)'(1);
   assign floor_plus = adapt_r.floor_quarter ? (cs_plus >> 2) : (cs_plus >> 1);
   assign floor_val  = (floor_plus == '0) ? '0 : SCALE_W'(floor_plus - (SCALE_W + 1)'(1));

   // ------------------------------------------------------------
   // Adaptive scale control
   // ------------------------------------------------------------
   logic [SCALE_W-1:0] scale_r_act;
   logic [5:0]         dec_cnt_r;
   logic               sample_low;
   logic               sample_high;

   assign sample_low  = ({1'b0, load_value} < lower_thr);
   assign sample_high = ({1'b0, load_value} >= upper_thr);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dec_cnt_r <= 6'h0;
      end else if (!adapt_on || !load_valid || !sample_high) begin
         if (!adapt_on)
            dec_cnt_r <= 6'h0;
      end else if (dec_cnt_r + 6'h1 >= dec_samples) begin
         dec_cnt_r <= 6'h0;
      end else begin
         dec_cnt_r <= dec_cnt_r + 6'h1;
      end
   end

   // Clamps keep the value inside [floor, cs]; a cs lowered below the
   // running value pulls it down on the following edge, one cycle after the setting moves
   logic [SCALE_W+3:0] inc_sum;
   assign inc_sum = (SCALE_W + 4)'(scale_r_act) + (SCALE_W + 4)'(inc_step);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scale_r_act <= '0;
      end else if (!adapt_on) begin
         scale_r_act <= scale_r.cs;
      end else if (scale_r_act > scale_r.cs) begin
         scale_r_act <= scale_r.cs;
      end else if (scale_r_act < floor_val) begin
         scale_r_act <= floor_val;
      end else if (load_valid && sample_low) begin
         if (inc_sum > (SCALE_W + 4)'(scale_r.cs))
            scale_r_act <= scale_r.cs;
         else
            scale_r_act <= SCALE_W'(inc_sum);
      end else if (load_valid && sample_high
                   && dec_cnt_r + 6'h1 >= dec_samples) begin
         if (scale_r_act > floor_val)
            scale_r_act <= scale_r_act - SCALE_W'(1);
      end
   end

   assign active_scale = scale_r_act;

   // ------------------------------------------------------------
   // Coil current scaling: cur * (scale+1) / 32
   // ------------------------------------------------------------
   logic signed [CUR_W+6:0] prod_a;
   logic signed [CUR_W+6:0] prod_b;
   assign prod_a = (CUR_W + 7)'(cur_a_in) * signed'({1'b0, cs_sel_plus()});
   assign prod_b = (CUR_W + 7)'(cur_b_in) * signed'({1'b0, cs_sel_plus()});

   function automatic logic [SCALE_W:0] cs_sel_plus();
      cs_sel_plus = (SCALE_W + 1)'(scale_r_act) + (SCALE_W + 1)'(1);
   endfunction

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cur_a_out <= '0;
         cur_b_out <= '0;
      end else begin
         cur_a_out <= CUR_W'(prod_a >>> SCALE_W);
         cur_b_out <= CUR_W'(prod_b >>> SCALE_W);
      end
   end
endmodule
